// *** shared/bfsp_pkg.sv ***
// bfsp_pkg: shared constants and types for the boot flash section protect block
// assumes: one core clock, register port with two address bits and byte data
package bfsp_pkg;

   // ==========================================================================
   // register map (word indices on the plain register port)
   localparam logic [1:0] REG_CTRL       = 2'h0;   // self_program_control_reg
   localparam logic [1:0] REG_LOCK       = 2'h1;   // boot lock bits, read only
   localparam logic [1:0] REG_STAT       = 2'h2;   // block state, read only

   // ==========================================================================
   // self_program_control_reg field positions
   localparam int CTRL_EN_POS    = 0;              // store enable
   localparam int CTRL_ERASE_POS = 1;              // page erase
   localparam int CTRL_WRITE_POS = 2;              // page write
   localparam int CTRL_LOCK_POS  = 3;              // boot lock set
   localparam int CTRL_RWWRE_POS = 4;              // read_while_write_region re-enable
   localparam int CTRL_BUSY_POS  = 6;              // rww_busy_flag, read only
   localparam int CTRL_CMD_W     = 5;

   // legal command codes in the low five control bits; CMD_NONE is the idle value
   localparam logic [4:0] CMD_LOAD  = 5'h01;
   localparam logic [4:0] CMD_ERASE = 5'h03;
   localparam logic [4:0] CMD_WRITE = 5'h05;
   localparam logic [4:0] CMD_LOCK  = 5'h09;
   localparam logic [4:0] CMD_RWWRE = 5'h11;
   localparam logic [4:0] CMD_NONE  = 5'h00;

   // ==========================================================================
   // boot lock bit positions: app_lock_set low, boot_lock_set high
   localparam int LOCK_APP_WR_POS  = 0;            // app_write_lock_bit
   localparam int LOCK_APP_RD_POS  = 1;            // app_read_lock_bit
   localparam int LOCK_BOOT_WR_POS = 2;            // boot_write_lock_bit
   localparam int LOCK_BOOT_RD_POS = 3;            // boot_read_lock_bit
   localparam logic [3:0] LOCK_RST = 4'hF;         // unprogrammed, mode 1

   // ==========================================================================
   // timing and reset values
   localparam int         ARM_WIN_CYC = 4;         // store enable window, cycles
   localparam logic [2:0] ARM_WIN_LD  = 3'(ARM_WIN_CYC);
   localparam logic [7:0] RDATA_RST   = 8'h00;

   // status register field positions
   localparam int STAT_HALT_POS  = 0;
   localparam int STAT_BUSY_POS  = 1;
   localparam int STAT_SBLK_POS  = 2;
   localparam int STAT_LBLK_POS  = 3;

   // ==========================================================================
   // sequencer states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_BUSY  = 3'b100
   } bfsp_state_t;

endpackage : bfsp_pkg

// *** design/bfsp_section_classify.sv ***
// bfsp_section_classify: places one flash word address in its sections
// assumes: boundaries are word addresses, boot section at the top of flash
`timescale 1ns/10ps
module bfsp_section_classify #(
   parameter int ADDR_W = 12
) (
   // address and boundaries
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [ADDR_W-1:0] boot_start_i,
   input  wire logic [ADDR_W-1:0] no_read_while_write_region_start_i,
   // classification
   output logic                   in_boot_o,
   output logic                   in_no_read_while_write_region_o
);

   // ==========================================================================
   // compare against both boundaries
   assign in_boot_o = (addr_i >= boot_start_i);
   assign in_no_read_while_write_region_o = (addr_i >= no_read_while_write_region_start_i);

endmodule : bfsp_section_classify

// *** design/bfsp_protect.sv ***
// bfsp_protect: section and lock gating of program stores and loads
// assumes: cpu pulses store/load requests, flash macro reports done for erase/write
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps
// Summary of operation
// - stores start flash programming only when executed from boot_loader_section
// - a boot store may target any flash address, subject to locks
// - boot_size_fuses set the application/boot boundary; each section has own locks
// - programming read_while_write_region keeps cpu running, no-rww code readable
// - programming no_read_while_write_region halts the cpu until done
// - halt follows the programmed address region, not the fetch region
// - rww_busy_flag reads one while read_while_write_region is blocked
// - boot_loader_section always lies inside no_read_while_write_region
// - two independent boot lock sets, application and boot loader
// - lock bits set by software or programmer, cleared only by chip erase or reset
// - general memory lock modes do not affect self store or load
// - an all-ones lock set places no restriction on its section
// - programmed app write lock blocks stores to the application section
// - programmed app read lock blocks boot loads of the application section
// - app read lock with boot vectors disables interrupts while in application
// - programmed boot write lock blocks stores to the boot loader section
// - programmed boot read lock blocks application loads of boot section
// - boot read lock with app vectors disables interrupts while in boot section
// - busy flag sets on rww erase/write, clears on re-enable or page load
module bfsp_protect #(
   parameter int                ADDR_W       = 12,
   parameter logic [ADDR_W-1:0] BOOT_START_0 = 12'hC00,  // boot_size_fuses = 0
   parameter logic [ADDR_W-1:0] BOOT_START_1 = 12'hE00,
   parameter logic [ADDR_W-1:0] BOOT_START_2 = 12'hF00,
   parameter logic [ADDR_W-1:0] BOOT_START_3 = 12'hF80,
   parameter logic [ADDR_W-1:0] NO_READ_WHILE_WRITE_REGION_START   = 12'hC00
) (
   // clock and reset
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   // register port
   input  wire logic [1:0]        reg_addr_i,
   input  wire logic [7:0]        reg_wdata_i,
   input  wire logic              reg_we_i,
   input  wire logic              reg_re_i,
   output logic      [7:0]        reg_rdata_o,
   // cpu side
   input  wire logic [ADDR_W-1:0] exec_pc_i,
   input  wire logic [ADDR_W-1:0] z_addr_i,
   input  wire logic [7:0]        lock_data_i,
   input  wire logic              spm_req_i,
   input  wire logic              lpm_req_i,
   input  wire logic              ivec_in_boot_i,
   // fuses and external programming
   input  wire logic [1:0]        boot_size_fuses_i,
   input  wire logic              chip_erase_i,
   input  wire logic              ext_lock_we_i,
   input  wire logic [3:0]        ext_lock_data_i,
   // flash macro
   input  wire logic              flash_done_i,
   output logic                   flash_erase_o,
   output logic                   flash_write_o,
   output logic                   page_load_o,
   output logic                   rww_reenable_o,
   output logic      [ADDR_W-1:0] op_addr_o,
   // protection results
   output logic                   lpm_grant_o,
   output logic                   lpm_block_o,
   output logic                   spm_block_o,
   output logic                   cpu_halt_o,
   output logic                   int_disable_o,
   output logic                   rww_busy_o
);

   // ==========================================================================
   // state record
   typedef struct packed {
      bfsp_pkg::bfsp_state_t fsm;
      logic [4:0]            cmd;
      logic [2:0]            win;
      logic                  halt_no_read_while_write_region;
      logic                  rww_busy;
      logic [3:0]            lock;
      logic [7:0]            rdata;
      logic                  erase_p;
      logic                  write_p;
      logic                  load_p;
      logic                  reen_p;
      logic                  lpm_ok;
      logic                  lpm_blk;
      logic                  spm_blk;
      logic [ADDR_W-1:0]     op_addr;
   } bfsp_regs_t;

   bfsp_regs_t        st_ff;
   bfsp_regs_t        nxt_st;
   logic [ADDR_W-1:0] fuse_start;
   logic [ADDR_W-1:0] boot_start;
   logic              pc_boot;
   logic              pc_no_read_while_write_region;
   logic              z_boot;
   logic              z_no_read_while_write_region;
   logic              armed;
   logic              spm_take;
   logic              wr_locked;
   logic              rd_locked;
   logic [4:0]        wr_cmd;
   logic              cmd_legal;

   // ==========================================================================
   // section boundary from fuses, clamped into the no-rww region
   always_comb begin
      unique case (boot_size_fuses_i)
         2'd0: fuse_start = BOOT_START_0;
         2'd1: fuse_start = BOOT_START_1;
         2'd2: fuse_start = BOOT_START_2;
         2'd3: fuse_start = BOOT_START_3;
      endcase
   end
   assign boot_start = (fuse_start < NO_READ_WHILE_WRITE_REGION_START) ? NO_READ_WHILE_WRITE_REGION_START : fuse_start;

   // classify the executing pc and the target address
   bfsp_section_classify #(
      .ADDR_W       (ADDR_W)
   ) u_pc_class (
      .addr_i       (exec_pc_i),
      .boot_start_i (boot_start),
      .no_read_while_write_region_start_i (NO_READ_WHILE_WRITE_REGION_START),
      .in_boot_o    (pc_boot),
      .in_no_read_while_write_region_o    (pc_no_read_while_write_region)
   );

   bfsp_section_classify #(
      .ADDR_W       (ADDR_W)
   ) u_z_class (
      .addr_i       (z_addr_i),
      .boot_start_i (boot_start),
      .no_read_while_write_region_start_i (NO_READ_WHILE_WRITE_REGION_START),
      .in_boot_o    (z_boot),
      .in_no_read_while_write_region_o    (z_no_read_while_write_region)
   );

   // ==========================================================================
   // access decisions; general lock modes are deliberately not consulted
   assign armed     = (st_ff.fsm == bfsp_pkg::ST_ARMED);
   assign spm_take  = armed && spm_req_i && pc_boot;
   assign wr_locked = z_boot ? !st_ff.lock[bfsp_pkg::LOCK_BOOT_WR_POS]
                             : !st_ff.lock[bfsp_pkg::LOCK_APP_WR_POS];
   assign rd_locked = (pc_boot && !z_boot && !st_ff.lock[bfsp_pkg::LOCK_APP_RD_POS])
                   || (!pc_boot && z_boot && !st_ff.lock[bfsp_pkg::LOCK_BOOT_RD_POS]);

   // interrupts masked while running in a read-locked section whose vectors sit in the other section
   assign int_disable_o = (ivec_in_boot_i && !pc_boot && !st_ff.lock[bfsp_pkg::LOCK_APP_RD_POS])
                       || (!ivec_in_boot_i && pc_boot && !st_ff.lock[bfsp_pkg::LOCK_BOOT_RD_POS]);

   // control write decode, only the listed combinations arm the window
   assign wr_cmd    = reg_wdata_i[bfsp_pkg::CTRL_CMD_W-1:0];
   assign cmd_legal = (wr_cmd == bfsp_pkg::CMD_LOAD)  || (wr_cmd == bfsp_pkg::CMD_ERASE)
                   || (wr_cmd == bfsp_pkg::CMD_WRITE) || (wr_cmd == bfsp_pkg::CMD_LOCK)
                   || (wr_cmd == bfsp_pkg::CMD_RWWRE);

   // ==========================================================================
   // next-state logic
   always_comb begin
      nxt_st         = st_ff;
      nxt_st.erase_p = 1'b0;
      nxt_st.write_p = 1'b0;
      nxt_st.load_p  = 1'b0;
      nxt_st.reen_p  = 1'b0;
      nxt_st.lpm_ok  = 1'b0;
      nxt_st.lpm_blk = 1'b0;
      nxt_st.spm_blk = 1'b0;
      nxt_st.rdata   = bfsp_pkg::RDATA_RST;

      // sequencer: arm, window, busy
      unique case (st_ff.fsm)
         bfsp_pkg::ST_IDLE: begin
            if (reg_we_i && (reg_addr_i == bfsp_pkg::REG_CTRL) && cmd_legal) begin
               nxt_st.fsm = bfsp_pkg::ST_ARMED;
               nxt_st.cmd = wr_cmd;
               nxt_st.win = bfsp_pkg::ARM_WIN_LD;
            end
         end
         bfsp_pkg::ST_ARMED: begin
            if (spm_req_i && !spm_take) begin
               nxt_st.fsm     = bfsp_pkg::ST_IDLE;
               nxt_st.cmd     = bfsp_pkg::CMD_NONE;
               nxt_st.spm_blk = 1'b1;
            end else if (spm_take) begin
               nxt_st.fsm = bfsp_pkg::ST_IDLE;
               nxt_st.cmd = bfsp_pkg::CMD_NONE;
               unique case (st_ff.cmd)
                  bfsp_pkg::CMD_ERASE,
                  bfsp_pkg::CMD_WRITE: begin
                     if (wr_locked) begin
                        nxt_st.spm_blk = 1'b1;
                     end else begin
                        nxt_st.fsm       = bfsp_pkg::ST_BUSY;
                        nxt_st.cmd       = st_ff.cmd;
                        nxt_st.op_addr   = z_addr_i;
                        nxt_st.erase_p   = (st_ff.cmd == bfsp_pkg::CMD_ERASE);
                        nxt_st.write_p   = (st_ff.cmd == bfsp_pkg::CMD_WRITE);
                        nxt_st.halt_no_read_while_write_region = z_no_read_while_write_region;
                        if (!z_no_read_while_write_region) begin
                           nxt_st.rww_busy = 1'b1;
                        end
                     end
                  end
                  bfsp_pkg::CMD_LOAD: begin
                     nxt_st.load_p   = 1'b1;
                     nxt_st.op_addr  = z_addr_i;
                     nxt_st.rww_busy = 1'b0;
                  end
                  bfsp_pkg::CMD_LOCK: begin
                     // bits may only be programmed, never released here
                     nxt_st.lock = st_ff.lock & lock_data_i[3:0];
                  end
                  bfsp_pkg::CMD_RWWRE: begin
                     nxt_st.reen_p   = 1'b1;
                     nxt_st.rww_busy = 1'b0;
                  end
                  default: begin
                     nxt_st.fsm = bfsp_pkg::ST_IDLE;
                  end
               endcase
            end else if (st_ff.win == 3'd1) begin
               nxt_st.fsm = bfsp_pkg::ST_IDLE;
               nxt_st.cmd = bfsp_pkg::CMD_NONE;
            end else begin
               nxt_st.win = st_ff.win - 3'd1;
            end
         end
         bfsp_pkg::ST_BUSY: begin
            if (flash_done_i) begin
               nxt_st.fsm       = bfsp_pkg::ST_IDLE;
               nxt_st.cmd       = bfsp_pkg::CMD_NONE;
               nxt_st.halt_no_read_while_write_region = 1'b0;
            end
         end
         default: begin
            nxt_st.fsm = bfsp_pkg::ST_IDLE;
         end
      endcase

      // program-memory load gating
      if (lpm_req_i) begin
         nxt_st.lpm_ok  = !rd_locked;
         nxt_st.lpm_blk = rd_locked;
      end

      // external programmer sets bits; chip erase alone releases them
      if (ext_lock_we_i) begin
         nxt_st.lock = nxt_st.lock & ext_lock_data_i;
      end
      if (chip_erase_i) begin
         nxt_st.lock = bfsp_pkg::LOCK_RST;
      end

      // register read data, valid the cycle after the strobe
      if (reg_re_i) begin
         unique case (reg_addr_i)
            bfsp_pkg::REG_CTRL: begin
               nxt_st.rdata                         = {3'b000, st_ff.cmd};
               nxt_st.rdata[bfsp_pkg::CTRL_BUSY_POS] = st_ff.rww_busy;
            end
            bfsp_pkg::REG_LOCK: begin
               nxt_st.rdata = {4'h0, st_ff.lock};
            end
            bfsp_pkg::REG_STAT: begin
               nxt_st.rdata[bfsp_pkg::STAT_HALT_POS] = cpu_halt_o;
               nxt_st.rdata[bfsp_pkg::STAT_BUSY_POS] = (st_ff.fsm == bfsp_pkg::ST_BUSY);
               nxt_st.rdata[bfsp_pkg::STAT_SBLK_POS] = st_ff.spm_blk;
               nxt_st.rdata[bfsp_pkg::STAT_LBLK_POS] = st_ff.lpm_blk;
            end
            default: begin
               nxt_st.rdata = bfsp_pkg::RDATA_RST;
            end
         endcase
      end
   end

   // ==========================================================================
   // state register
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff           <= '0;
         st_ff.fsm       <= bfsp_pkg::ST_IDLE;
         st_ff.lock      <= bfsp_pkg::LOCK_RST;
         st_ff.rdata     <= bfsp_pkg::RDATA_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================================
   // outputs
   assign reg_rdata_o    = st_ff.rdata;
   assign flash_erase_o  = st_ff.erase_p;
   assign flash_write_o  = st_ff.write_p;
   assign page_load_o    = st_ff.load_p;
   assign rww_reenable_o = st_ff.reen_p;
   assign op_addr_o      = st_ff.op_addr;
   assign lpm_grant_o    = st_ff.lpm_ok;
   assign lpm_block_o    = st_ff.lpm_blk;
   assign spm_block_o    = st_ff.spm_blk;
   assign cpu_halt_o     = (st_ff.fsm == bfsp_pkg::ST_BUSY) && st_ff.halt_no_read_while_write_region;
   assign rww_busy_o     = st_ff.rww_busy;

   // ==========================================================================
   // assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_store_from_app: assert property (
      (armed && spm_req_i && !pc_boot) |=> (!flash_erase_o && !flash_write_o && !page_load_o && spm_block_o))
      else $error("store from application section was not dropped");

   a_app_write_lock: assert property (
      (spm_take && !z_boot && !st_ff.lock[bfsp_pkg::LOCK_APP_WR_POS]) |=> (!flash_erase_o && !flash_write_o))
      else $error("store reached a write-locked application section");

   a_boot_write_lock: assert property (
      (spm_take && z_boot && !st_ff.lock[bfsp_pkg::LOCK_BOOT_WR_POS]) |=> (!flash_erase_o && !flash_write_o))
      else $error("store reached a write-locked boot section");

   a_rww_busy_set: assert property (
      ((flash_erase_o || flash_write_o) && !cpu_halt_o) |-> rww_busy_o)
      else $error("busy flag not set by rww programming");

   a_halt_held: assert property (
      (cpu_halt_o && !flash_done_i) |=> cpu_halt_o)
      else $error("cpu released before no_read_while_write_region programming finished");

   a_halt_by_target: assert property (
      (spm_take && !wr_locked && ((st_ff.cmd == bfsp_pkg::CMD_ERASE) || (st_ff.cmd == bfsp_pkg::CMD_WRITE)))
      |=> (cpu_halt_o == $past(z_no_read_while_write_region)))
      else $error("halt does not follow target region");

   a_app_read_lock: assert property (
      (lpm_req_i && pc_boot && !z_boot && !st_ff.lock[bfsp_pkg::LOCK_APP_RD_POS]) |=> (lpm_block_o && !lpm_grant_o))
      else $error("boot load read a read-locked application section");

   a_boot_read_lock: assert property (
      (lpm_req_i && !pc_boot && z_boot && !st_ff.lock[bfsp_pkg::LOCK_BOOT_RD_POS]) |=> (lpm_block_o && !lpm_grant_o))
      else $error("application load read a read-locked boot section");

   a_lock_no_release: assert property (
      !chip_erase_i |=> ((st_ff.lock & ~$past(st_ff.lock)) == 4'h0))
      else $error("lock bit released without chip erase");

   a_int_mask: assert property (
      (ivec_in_boot_i && !pc_boot && !st_ff.lock[bfsp_pkg::LOCK_APP_RD_POS]) |-> int_disable_o)
      else $error("interrupts left enabled in read-locked application");

endmodule : bfsp_protect

// *** dv/bfsp_cpu_model.sv ***
// bfsp_cpu_model: cpu stand-in issuing program store and load requests
// assumes: the bench calls req, one core clock, one request at a time
`timescale 1ns/10ps
module bfsp_cpu_model (
   // clock
   input  wire logic        core_clk_i,
   // request side
   output logic      [11:0] exec_pc_o,
   output logic      [11:0] z_addr_o,
   output logic      [7:0]  lock_data_o,
   output logic             spm_req_o,
   output logic             lpm_req_o
);
   // ==========================================================================
   // idle values at time zero
   initial begin
      exec_pc_o   = 12'h000;
      z_addr_o    = 12'h000;
      lock_data_o = 8'hFF;
      spm_req_o   = 1'b0;
      lpm_req_o   = 1'b0;
   end
   // one request after gap cycles; pointer and data scrambled once taken
   task automatic req(input logic ld_op, input logic [11:0] pc, input logic [11:0] z,
                      input logic [7:0] ld, input int gap);
      repeat (gap) @(posedge core_clk_i);
      exec_pc_o   <= pc;
      z_addr_o    <= z;
      lock_data_o <= ld;
      spm_req_o   <= !ld_op;
      lpm_req_o   <= ld_op;
      @(posedge core_clk_i);
      spm_req_o   <= 1'b0;
      lpm_req_o   <= 1'b0;
      z_addr_o    <= ~z;
      lock_data_o <= ~ld;
   endtask : req
endmodule : bfsp_cpu_model

// *** dv/tb_top.sv ***
// tb_top: self-checking bench for bfsp_protect with a cpu stand-in
// assumes: default section boundaries, 4 ns clock, drivers queue expectations
`timescale 1ns/10ps
module tb_top;
   // ==========================================================================
   // signals and bookkeeping
   logic core_clk_i = 1'b0, rst_i = 1'b1, reg_we_i = 1'b0, reg_re_i = 1'b0, ivec_in_boot_i = 1'b0;
   logic chip_erase_i = 1'b0, ext_lock_we_i = 1'b0, flash_done_i = 1'b0, re_seen = 1'b0;
   logic [1:0] reg_addr_i = 2'h0, boot_size_fuses_i = 2'h0;
   logic [3:0] ext_lock_data_i = 4'hF;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, lock_data_i;
   logic [11:0] exec_pc_i, z_addr_i, op_addr_o;
   logic spm_req_i, lpm_req_i, flash_erase_o, flash_write_o, page_load_o, rww_reenable_o;
   logic lpm_grant_o, lpm_block_o, spm_block_o, cpu_halt_o, int_disable_o, rww_busy_o;
   logic [11:0] bs [4] = '{12'hC00, 12'hE00, 12'hF00, 12'hF80};
   logic [31:0] seed = 32'h0001_6873;
   logic [4:0] sq[$];
   logic [1:0] lq[$];
   logic [7:0] rq[$];
   int error_cnt = 0, n_tests = 0;
   always #2 core_clk_i = ~core_clk_i;
   bfsp_protect i_bfsp_protect (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
      .exec_pc_i(exec_pc_i), .z_addr_i(z_addr_i), .lock_data_i(lock_data_i), .spm_req_i(spm_req_i),
      .lpm_req_i(lpm_req_i), .ivec_in_boot_i(ivec_in_boot_i), .boot_size_fuses_i(boot_size_fuses_i),
      .chip_erase_i(chip_erase_i), .ext_lock_we_i(ext_lock_we_i), .ext_lock_data_i(ext_lock_data_i),
      .flash_done_i(flash_done_i), .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o),
      .page_load_o(page_load_o), .rww_reenable_o(rww_reenable_o), .op_addr_o(op_addr_o),
      .lpm_grant_o(lpm_grant_o), .lpm_block_o(lpm_block_o), .spm_block_o(spm_block_o),
      .cpu_halt_o(cpu_halt_o), .int_disable_o(int_disable_o), .rww_busy_o(rww_busy_o));
   bfsp_cpu_model i_bfsp_cpu_model (.core_clk_i(core_clk_i), .exec_pc_o(exec_pc_i), .z_addr_o(z_addr_i),
      .lock_data_o(lock_data_i), .spm_req_o(spm_req_i), .lpm_req_o(lpm_req_i));
   // ==========================================================================
   // compare, report and close
   task automatic report(input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (e !== g) begin
         error_cnt++;
         $display("mismatch at %0t: expected %h got %h", $time, e, g);
      end
   endtask : report
   task automatic cmp_evt(input logic [7:0] e, input logic [7:0] g); report({8'h00, e}, {8'h00, g}); endtask : cmp_evt
   task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g); report({8'h00, e}, {8'h00, g}); endtask : cmp_reg
   task automatic cmp_lvl(input logic [15:0] e, input logic [15:0] g); report(e, g); endtask : cmp_lvl
   task automatic end_of_test;
      if (sq.size() + lq.size() + rq.size() != 0) error_cnt++;
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   // ==========================================================================
   // drivers: register port, flash done, store and load
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      reg_addr_i <= a;
      reg_re_i <= 1'b1;
      rq.push_back(e);
      @(posedge core_clk_i);
      reg_re_i <= 1'b0;
   endtask : rd
   task automatic pulse_done;
      @(posedge core_clk_i);
      flash_done_i <= 1'b1;
      @(posedge core_clk_i);
      flash_done_i <= 1'b0;
   endtask : pulse_done
   // pseudo-random source for gaps and target addresses
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // arm a command, store after a random gap, then check halt and busy
   task automatic op(input logic [4:0] c, input logic [11:0] pc, input logic [11:0] z, input logic [7:0] ld,
                     input logic [4:0] ev, input logic [1:0] lv);
      seed = lfsr(seed);
      @(posedge core_clk_i);
      reg_addr_i <= 2'h0;
      reg_wdata_i <= {3'h0, c};
      reg_we_i <= 1'b1;
      @(posedge core_clk_i);
      reg_we_i <= 1'b0;
      if (ev != 5'h00) sq.push_back(ev);
      i_bfsp_cpu_model.req(1'b0, pc, z, ld, int'(seed[1:0] % 3));
      @(negedge core_clk_i);
      cmp_lvl({14'h0, lv}, {14'h0, cpu_halt_o, rww_busy_o});
   endtask : op
   task automatic ld(input logic [11:0] pc, input logic [11:0] z, input logic [1:0] e);
      lq.push_back(e);
      i_bfsp_cpu_model.req(1'b1, pc, z, 8'hFF, 1);
   endtask : ld
   // monitor: oldest note taken off its queue whenever a result appears
   always @(posedge core_clk_i) begin
      if (|{flash_erase_o, flash_write_o, page_load_o, rww_reenable_o, spm_block_o})
         cmp_evt(sq.size() ? {3'h0, sq.pop_front()} : 8'h00, {3'h0, flash_erase_o, flash_write_o, page_load_o,
                 rww_reenable_o, spm_block_o});
      if (lpm_grant_o | lpm_block_o)
         cmp_evt(lq.size() ? {6'h0, lq.pop_front()} : 8'h00, {6'h0, lpm_grant_o, lpm_block_o});
      if (re_seen)
         cmp_reg(rq.size() ? rq.pop_front() : 8'hxx, reg_rdata_o);
      re_seen <= reg_re_i;
   end
   // watchdog
   initial begin
      #80000;
      error_cnt++;
      end_of_test();
   end
   // ==========================================================================
   // main sequence
   initial begin
      repeat (3) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rd(2'h1, {4'h0, bfsp_pkg::LOCK_RST});
      rd(2'h3, 8'h00);
      $display("test reset done");
      for (int f = 0; f < 4; f++) begin
         boot_size_fuses_i <= 2'(f);
         op(bfsp_pkg::CMD_ERASE, bs[f], {2'b00, seed[9:0]}, 8'hFF, 5'b10000, 2'b01);
         pulse_done();
         op(bfsp_pkg::CMD_ERASE, bs[f] - 12'h001, 12'h010, 8'hFF, 5'b00001, 2'b01);
         op(bfsp_pkg::CMD_RWWRE, bs[f], 12'h000, 8'hFF, 5'b00010, 2'b00);
      end
      $display("test sections done");
      boot_size_fuses_i <= 2'h0;
      op(bfsp_pkg::CMD_WRITE, 12'hC00, 12'hF80, 8'hFF, 5'b01000, 2'b10);
      cmp_lvl(16'h0F80, {4'h0, op_addr_o});
      repeat (5) @(negedge core_clk_i) cmp_lvl(16'h0001, {15'h0, cpu_halt_o});
      pulse_done();
      @(negedge core_clk_i) cmp_lvl(16'h0000, {15'h0, cpu_halt_o});
      op(bfsp_pkg::CMD_ERASE, 12'hC00, 12'h200, 8'hFF, 5'b10000, 2'b01);
      rd(2'h0, 8'h43);
      rd(2'h2, 8'h02);
      pulse_done();
      op(bfsp_pkg::CMD_LOAD, 12'hC00, 12'h200, 8'hFF, 5'b00100, 2'b00);
      $display("test programming done");
      op(bfsp_pkg::CMD_LOCK, 12'hC00, 12'h000, 8'hF8, 5'b00000, 2'b00);
      rd(2'h1, 8'h08);
      op(bfsp_pkg::CMD_ERASE, 12'hC00, 12'h100, 8'hFF, 5'b00001, 2'b00);
      op(bfsp_pkg::CMD_ERASE, 12'hC00, 12'hC40, 8'hFF, 5'b00001, 2'b00);
      ld(12'hC00, 12'h100, 2'b01);
      ld(12'h100, 12'hC40, 2'b10);
      ivec_in_boot_i <= 1'b1;
      @(negedge core_clk_i) cmp_lvl(16'h0001, {15'h0, int_disable_o});
      @(posedge core_clk_i);
      ext_lock_we_i <= 1'b1;
      ext_lock_data_i <= 4'h7;
      @(posedge core_clk_i);
      ext_lock_we_i <= 1'b0;
      ivec_in_boot_i <= 1'b0;
      ld(12'h100, 12'hC40, 2'b01);
      ld(12'hC40, 12'h100, 2'b01);
      @(negedge core_clk_i) cmp_lvl(16'h0001, {15'h0, int_disable_o});
      @(posedge core_clk_i);
      chip_erase_i <= 1'b1;
      @(posedge core_clk_i);
      chip_erase_i <= 1'b0;
      rd(2'h1, 8'h0F);
      ld(12'hC00, 12'h100, 2'b10);
      repeat (3) @(posedge core_clk_i);
      $display("test locks done");
      end_of_test();
   end
endmodule : tb_top
